//--- rtl/air_image_mem.sv
/*
 * Byte memory for one analog image, both segments, 512 bytes.
 * One write port and one read port whose data come from a register.
 * Assumes both ports run on the block clock.
 */
`timescale 1ns/1ns
module air_image_mem (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // write port
    input  wire logic       wrEn,
    input  wire logic [8:0] wrAddr,
    input  wire logic [7:0] wrData,
    // read port
    input  wire logic [8:0] rdAddr,
    output logic      [7:0] rdData_r
);

    logic [7:0] memArray [0:511];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= memArray[rdAddr];
        end
    end

endmodule

//--- rtl/air_pkg.sv
/*
 * Shared constants of the analog image record access block: request
 * indexes, slot and subslot codes, response byte layout, status codes
 * and the state enumeration of the request sequencer.
 * Assumes one 100 MHz clock and a synchronous active-high reset.
 */
package air_pkg;

    localparam logic [15:0] IDX_INPUT_IMAGE  = 16'h0019;
    localparam logic [15:0] IDX_OUTPUT_IMAGE = 16'h001A;
    localparam logic [15:0] IDX_DELTA_LIST   = 16'h0040;

    localparam logic [15:0] SLOT_SEG1        = 16'h0000;
    localparam logic [15:0] SLOT_SEG2        = 16'h0064;
    localparam logic [15:0] SUBSLOT_SERVICE  = 16'h0001;

    localparam logic [7:0]  IMG_FIRST_DATA   = 8'h02;
    localparam logic [7:0]  IMG_LAST_DATA    = 8'hF9;
    localparam logic [7:0]  IMG_LAST_BYTE    = 8'hFB;
    localparam logic [7:0]  DL_FIRST_DATA    = 8'h02;
    localparam logic [7:0]  DL_LAST_DATA     = 8'h09;
    localparam logic [7:0]  DL_LAST_BYTE     = 8'h0B;

    localparam logic [7:0]  STATUS_OK        = 8'h00;
    localparam logic [7:0]  STATUS_FAIL      = 8'h01;

    localparam logic [1:0]  FIFO_DEPTH       = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ADDR,
        ST_RD_PUSH,
        ST_WR_RECV,
        ST_STATUS
    } air_state_t;

    // addressing check shared by reads and writes
    function automatic logic airAddrValid(input logic [15:0] slot,
                                          input logic [15:0] subslot);
        airAddrValid = ((slot == SLOT_SEG1) || (slot == SLOT_SEG2))
                       && (subslot == SUBSLOT_SERVICE);
    endfunction

endpackage

//--- rtl/air_record_access.sv
/*
 * Record access handler for the analog images and the delta list.
 * Takes one request at a time, streams the response bytes through a
 * two-entry buffer, receives output image writes byte by byte.
 * Assumes the master side updates the input image, reads the output
 * image and reports its status and delta list on the same clock.
 */
`timescale 1ns/1ns
module air_record_access
    import air_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // record request
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [15:0] reqIndex,
    input  wire logic [15:0] reqSlot,
    input  wire logic [15:0] reqSubslot,
    output logic             reqReady_r,
    // write data stream
    input  wire logic        wrValid,
    input  wire logic [7:0]  wrByte,
    output logic             wrReady_r,
    // response stream
    output logic             rspValid_r,
    output logic [7:0]       rspByte_r,
    output logic             rspLast_r,
    input  wire logic        rspReady,
    // master side: status and delta list
    input  wire logic [1:0]  segMasterOk,
    input  wire logic [63:0] deltaListSeg1,
    input  wire logic [63:0] deltaListSeg2,
    // master side: input image update
    input  wire logic        inImgWrEn,
    input  wire logic        inImgWrSeg,
    input  wire logic [7:0]  inImgWrOffset,
    input  wire logic [7:0]  inImgWrData,
    // master side: output image fetch
    input  wire logic        outImgRdSeg,
    input  wire logic [7:0]  outImgRdOffset,
    output logic      [7:0]  outImgRdData_r
);

    ////////////////////////////////////////////////////////////////////
    // request state
    air_state_t  state_r;
    air_state_t  state_nxt;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;
    logic        seg_r;
    logic        isDelta_r;
    logic        wrAccept_r;
    logic        wrOk_r;
    logic [7:0]  lastByte_r;

    wire         reqTake   = reqValid && reqReady_r;
    wire         wrTake    = wrValid && wrReady_r;
    wire         addrOk    = airAddrValid(reqSlot, reqSubslot);
    wire         reqSeg    = (reqSlot == SLOT_SEG2);
    wire         rdImage   = !reqWrite && (reqIndex == IDX_INPUT_IMAGE);
    wire         rdDelta   = !reqWrite && (reqIndex == IDX_DELTA_LIST);
    wire         rdServed  = addrOk && (rdImage || rdDelta);
    wire         wrTarget  = reqWrite && addrOk && (reqIndex == IDX_OUTPUT_IMAGE);

    ////////////////////////////////////////////////////////////////////
    // two-entry response buffer
    logic [8:0]  fifoE0_r;
    logic [8:0]  fifoE1_r;
    logic [1:0]  fifoCnt_r;
    logic [1:0]  fifoCnt_nxt;
    logic        pushValid;
    logic [7:0]  pushByte;
    logic        pushLast;

    wire         pushReady = (fifoCnt_r != FIFO_DEPTH);
    wire         push      = pushValid && pushReady;
    wire         pop       = rspValid_r && rspReady;

    assign fifoCnt_nxt = fifoCnt_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fifoCnt_r <= 2'h0;
            fifoE0_r  <= 9'h000;
            fifoE1_r  <= 9'h000;
        end else begin
            fifoCnt_r <= fifoCnt_nxt;
            if (pop && (fifoCnt_r == FIFO_DEPTH)) begin
                fifoE0_r <= fifoE1_r;
            end else if (push && ((fifoCnt_r == 2'h0) || pop)) begin
                fifoE0_r <= {pushLast, pushByte};
            end else if (push) begin
                fifoE1_r <= {pushLast, pushByte};
            end
        end
    end

    // outputs follow the head entry from flops
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rspValid_r <= 1'b0;
            rspByte_r  <= 8'h00;
            rspLast_r  <= 1'b0;
        end else begin
            rspValid_r <= (fifoCnt_nxt != 2'h0);
            if (pop && (fifoCnt_r == FIFO_DEPTH)) begin
                {rspLast_r, rspByte_r} <= fifoE1_r;
            end else if (push && ((fifoCnt_r == 2'h0) || pop)) begin
                {rspLast_r, rspByte_r} <= {pushLast, pushByte};
            end else begin
                {rspLast_r, rspByte_r} <= fifoE0_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // image memories
    logic [7:0]  inImgRdData;
    wire  [7:0]  imgOffset   = cnt_r - IMG_FIRST_DATA;
    wire         imgDataByte = (cnt_r >= IMG_FIRST_DATA) && (cnt_r <= IMG_LAST_DATA);
    // write bytes 0, 1, 250, 251 dropped
    wire         outImgWrEn  = wrTake && wrAccept_r && imgDataByte;

    // eight bytes per node from byte 2
    air_image_mem u_in_img (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wrEn     (inImgWrEn),
        .wrAddr   ({inImgWrSeg, inImgWrOffset}),
        .wrData   (inImgWrData),
        .rdAddr   ({seg_r, imgOffset}),
        .rdData_r (inImgRdData)
    );

    // same layout as the input image
    air_image_mem u_out_img (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wrEn     (outImgWrEn),
        .wrAddr   ({seg_r, imgOffset}),
        .wrData   (wrByte),
        .rdAddr   ({outImgRdSeg, outImgRdOffset}),
        .rdData_r (outImgRdData_r)
    );

    ////////////////////////////////////////////////////////////////////
    // response byte selection
    wire  [63:0] deltaSel   = seg_r ? deltaListSeg2 : deltaListSeg1;
    wire  [7:0]  deltaOff   = cnt_r - DL_FIRST_DATA;
    wire         deltaData  = (cnt_r >= DL_FIRST_DATA) && (cnt_r <= DL_LAST_DATA);
    // one bit per address, A then B
    wire  [7:0]  deltaByte  = deltaData ? deltaSel[{deltaOff[2:0], 3'h0} +: 8] : 8'h00;
    wire  [7:0]  imageByte  = imgDataByte ? inImgRdData : 8'h00;
    wire         atLast     = (cnt_r == lastByte_r);
    wire  [7:0]  streamByte = atLast ? STATUS_OK : (isDelta_r ? deltaByte : imageByte);

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        pushValid = 1'b0;
        pushByte  = 8'h00;
        pushLast  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = 8'h00;
                if (reqTake && reqWrite) begin
                    state_nxt = ST_WR_RECV;
                end else if (reqTake && rdServed) begin
                    state_nxt = ST_RD_ADDR;
                end else if (reqTake) begin
                    state_nxt = ST_STATUS;
                end
            end
            ST_RD_ADDR: begin
                state_nxt = ST_RD_PUSH;
            end
            ST_RD_PUSH: begin
                pushValid = 1'b1;
                pushByte  = streamByte;
                pushLast  = atLast;
                if (pushReady && atLast) begin
                    state_nxt = ST_IDLE;
                end else if (pushReady) begin
                    cnt_nxt   = cnt_r + 8'h01;
                    state_nxt = ST_RD_ADDR;
                end
            end
            ST_WR_RECV: begin
                if (wrTake && (cnt_r == IMG_LAST_BYTE)) begin
                    state_nxt = ST_STATUS;
                end else if (wrTake) begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            ST_STATUS: begin
                pushValid = 1'b1;
                pushByte  = wrOk_r ? STATUS_OK : STATUS_FAIL;
                pushLast  = 1'b1;
                if (pushReady) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r    <= ST_IDLE;
            cnt_r      <= 8'h00;
            reqReady_r <= 1'b0;
            wrReady_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            reqReady_r <= (state_nxt == ST_IDLE);
            wrReady_r  <= (state_nxt == ST_WR_RECV);
        end
    end

    // request attributes captured at acceptance
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seg_r      <= 1'b0;
            isDelta_r  <= 1'b0;
            wrAccept_r <= 1'b0;
            wrOk_r     <= 1'b0;
            lastByte_r <= 8'h00;
        end else if (reqTake) begin
            seg_r      <= reqSeg;
            isDelta_r  <= rdDelta;
            lastByte_r <= rdDelta ? DL_LAST_BYTE : IMG_LAST_BYTE;
            wrAccept_r <= wrTarget && segMasterOk[reqSeg];
            wrOk_r     <= wrTarget && segMasterOk[reqSeg];
        end
    end

endmodule

//--- testbench/air_record_access_asserts.sv
/*
 * Port checker for the record access block.
 * Sees only the top ports, bound to every instance of the top.
 */
`timescale 1ns/1ns
module air_record_access_asserts
    import air_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // request and response
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic [15:0] reqIndex,
    input wire logic [15:0] reqSlot,
    input wire logic [15:0] reqSubslot,
    input wire logic        reqReady_r,
    input wire logic        wrReady_r,
    input wire logic        rspValid_r,
    input wire logic [7:0]  rspByte_r,
    input wire logic        rspLast_r,
    input wire logic        rspReady
);
    wire takeNow = reqValid && reqReady_r;
    wire addrOk  = ((reqSlot == SLOT_SEG1) || (reqSlot == SLOT_SEG2))
                   && (reqSubslot == SUBSLOT_SERVICE);
    wire rdImg   = takeNow && !reqWrite && addrOk && (reqIndex == IDX_INPUT_IMAGE);
    wire rdDelta = takeNow && !reqWrite && addrOk && (reqIndex == IDX_DELTA_LIST);
    wire rdBad   = takeNow && !reqWrite && !rdImg && !rdDelta;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_take_busy: assert property (takeNow |=> !reqReady_r)
        else $error("ready stayed high after a take");
    a_img_first: assert property (rdImg |->
        ##3 rspValid_r && rspByte_r == 8'h00 && !rspLast_r)
        else $error("image read did not open with a zero byte");
    a_img_quiet: assert property (rdImg |=> !rspValid_r [*2])
        else $error("image read answered early");
    a_delta_first: assert property (rdDelta |-> ##3 rspValid_r && rspByte_r == 8'h00)
        else $error("delta read did not open with a zero byte");
    a_bad_fail: assert property (rdBad |->
        ##2 rspValid_r && rspLast_r && rspByte_r == STATUS_FAIL)
        else $error("refused read did not give one failure byte");
    a_wr_open: assert property (takeNow && reqWrite |=> wrReady_r)
        else $error("write data not accepted after a write take");
    a_wr_busy: assert property (wrReady_r |-> !reqReady_r)
        else $error("request ready while write data pending");
    a_rsp_hold: assert property (rspValid_r && !rspReady |=>
        rspValid_r && $stable(rspByte_r) && $stable(rspLast_r))
        else $error("stalled response byte changed");
endmodule

bind air_record_access air_record_access_asserts u_chk (.sys_clk, .sys_rst, .reqValid, .reqWrite,
    .reqIndex, .reqSlot, .reqSubslot, .reqReady_r, .wrReady_r, .rspValid_r, .rspByte_r,
    .rspLast_r, .rspReady);

//--- testbench/air_record_access_tb.sv
/*
 * Self-checking bench of the record access block.
 * Assumes the checker is bound and the sink paces responses.
 */
`timescale 1ns/1ns
module air_record_access_tb
    import air_pkg::*;
;
    typedef struct packed {
        logic w; logic [15:0] idx; logic [15:0] slot; logic [15:0] sub;
        logic [1:0] ok; logic stall; logic [8:0] len; logic [7:0] st;
    } air_row_t;
    logic sys_clk = 1'h0, sys_rst = 1'h1, reqValid = 1'h0, reqWrite = 1'h0, wrValid = 1'h0;
    logic [15:0] reqIndex = 16'h0000, reqSlot = 16'h0000, reqSubslot = 16'h0000;
    logic [7:0] wrByte = 8'h00, inImgWrOffset = 8'h00, inImgWrData = 8'h00;
    logic [1:0] segMasterOk = 2'h3;
    logic inImgWrEn = 1'h0, inImgWrSeg = 1'h0, stallMode = 1'h0;
    logic [63:0] dl1 = 64'h0123456789ABCDEF, dl2 = 64'hFEDCBA9876543210;
    logic reqReady_r, wrReady_r, rspValid_r, rspLast_r, rspReady;
    logic [7:0] rspByte_r, outImgRdData_r;
    logic [8:0] rq [$];
    logic outImgRdSeg = 1'h0;
    logic [7:0] outImgRdOffset = 8'h00;
    air_row_t rows [11];
    int errors = 0, comparisons = 0;
    int good [2] = '{0, 0};

    always #5 sys_clk = ~sys_clk;

    air_record_access DUT (.sys_clk, .sys_rst, .reqValid, .reqWrite, .reqIndex, .reqSlot,
        .reqSubslot, .reqReady_r, .wrValid, .wrByte, .wrReady_r, .rspValid_r, .rspByte_r,
        .rspLast_r, .rspReady, .segMasterOk, .deltaListSeg1(dl1), .deltaListSeg2(dl2),
        .inImgWrEn, .inImgWrSeg, .inImgWrOffset, .inImgWrData, .outImgRdSeg,
        .outImgRdOffset, .outImgRdData_r);
    air_rsp_sink u_sink (.sys_clk, .sys_rst, .stallMode, .rspReady);

    always @(posedge sys_clk)
        if (rspValid_r === 1'h1 && rspReady) rq.push_back({rspLast_r, rspByte_r});

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [8:0] e, logic [8:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // waits at falling edges for a ready, then passes the taking edge
    task automatic waitHi(bit s);
        int t;
        for (t = 0; t < 3000 && (s ? reqReady_r : wrReady_r) !== 1'h1; t++) @(negedge sys_clk);
        if (t == 3000) begin errors++; report_and_stop(); end
        @(posedge sys_clk);
    endtask
    function automatic logic [8:0] expB(air_row_t x, int k);
        logic [7:0] v;
        v = 8'h00;
        if (k == x.len - 1) v = x.st;
        else if (x.idx == IDX_INPUT_IMAGE && k >= 2 && k <= 249)
            v = 8'(k - 2) + {x.slot[6], 7'h00};
        else if (x.idx == IDX_DELTA_LIST && k >= 2 && k <= 9)
            v = 8'((x.slot[6] ? dl2 : dl1) >> (8 * (k - 2)));
        return {k == x.len - 1, v};
    endfunction
    task automatic issue(air_row_t x);
        stallMode = x.stall; segMasterOk = x.ok; rq.delete();
        reqWrite = x.w; reqIndex = x.idx; reqSlot = x.slot; reqSubslot = x.sub; reqValid = 1'h1;
        waitHi(1);
        @(negedge sys_clk) reqValid = 1'h0;
    endtask
    task automatic runRow(air_row_t x, int r);
        int t;
        logic [8:0] ex;
        issue(x);
        if (x.w) begin
            for (int k = 0; k < 252; k++) begin
                wrByte = 8'(k) ^ 8'(r); wrValid = 1'h1; // image layout from byte 2
                waitHi(0);
                @(negedge sys_clk);
            end
            wrValid = 1'h0;
        end
        for (t = 0; t < 3000 && !(rq.size() > 0 && rq[$][8]); t++) @(negedge sys_clk);
        if (t == 3000) begin errors++; report_and_stop(); end
        chk("count", {1'h0, x.len[7:0]}, {1'h0, 8'(rq.size())});
        for (int k = 0; k < rq.size(); k++) chk("rspByte", expB(x, k), rq[k]);
        if (x.idx == IDX_OUTPUT_IMAGE) begin
            if (x.w && x.st == STATUS_OK) good[x.slot[6]] = r;
            // first and last stored byte of the addressed segment
            for (int j = 0; j < 2; j++) begin
                outImgRdSeg = x.slot[6];
                outImgRdOffset = 8'(j * 247);
                @(negedge sys_clk);
                ex = {1'h0, 8'(2 + j * 247) ^ 8'(good[x.slot[6]])};
                chk("outImg", ex, {1'h0, outImgRdData_r});
            end
        end
    endtask

    initial begin
        rows = '{'{1'h0, 16'h0019, 16'h0000, 16'h0001, 2'h3, 1'h0, 9'h0FC, 8'h00},
                 '{1'h0, 16'h0019, 16'h0064, 16'h0001, 2'h3, 1'h1, 9'h0FC, 8'h00},
                 '{1'h0, 16'h0040, 16'h0000, 16'h0001, 2'h3, 1'h0, 9'h00C, 8'h00},
                 '{1'h0, 16'h0040, 16'h0064, 16'h0001, 2'h3, 1'h1, 9'h00C, 8'h00},
                 '{1'h0, 16'h0019, 16'h0005, 16'h0001, 2'h3, 1'h0, 9'h001, 8'h01},
                 '{1'h0, 16'h0019, 16'h0000, 16'h0002, 2'h3, 1'h0, 9'h001, 8'h01},
                 '{1'h0, 16'h0041, 16'h0000, 16'h0001, 2'h3, 1'h0, 9'h001, 8'h01},
                 '{1'h1, 16'h001A, 16'h0000, 16'h0001, 2'h3, 1'h1, 9'h001, 8'h00},
                 '{1'h1, 16'h001A, 16'h0000, 16'h0001, 2'h2, 1'h0, 9'h001, 8'h01},
                 '{1'h1, 16'h0040, 16'h0064, 16'h0001, 2'h3, 1'h0, 9'h001, 8'h01},
                 '{1'h1, 16'h001A, 16'h0064, 16'h0001, 2'h2, 1'h0, 9'h001, 8'h00}};
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'h0;
        for (int i = 0; i < 496; i++) begin
            inImgWrEn = 1'h1; inImgWrSeg = i[0]; inImgWrOffset = 8'(i >> 1);
            inImgWrData = 8'(i >> 1) + {i[0], 7'h00};
            @(negedge sys_clk);
        end
        inImgWrEn = 1'h0;
        for (int r = 0; r < 11; r++) runRow(rows[r], r);
        // reset in mid response, then serve again
        issue(rows[1]);
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'h1;
        repeat (2) @(negedge sys_clk);
        chk("rstOut", 9'h000, {7'h00, reqReady_r, rspValid_r});
        sys_rst = 1'h0;
        @(negedge sys_clk);
        chk("rstRdy", 9'h001, {8'h00, reqReady_r});
        runRow(rows[2], 2);
        report_and_stop();
    end
endmodule

//--- testbench/air_rsp_sink.sv
/*
 * Response sink standing for the fieldbus controller.
 * Assumes the bench collects bytes; this only paces rspReady.
 */
`timescale 1ns/1ns
module air_rsp_sink (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // control
    input  wire logic stallMode,
    // response handshake
    output logic      rspReady
);
    logic [1:0] cnt_r;
    always_ff @(negedge sys_clk) begin
        cnt_r <= sys_rst ? 2'h0 : cnt_r + 2'h1;
    end
    // ready one cycle in four when stalling
    assign rspReady = !(stallMode && (cnt_r != 2'h3));
endmodule
